//--- rtl/bteb_blend.sv
// bteb_blend: alpha blend of two pixels, picture or per-pixel weight
`timescale 1ns/1ps
module bteb_blend (
  input wire logic [23:0] src0_pix, // source zero pixel
  input wire logic [23:0] src1_pix, // source one pixel
  input wire logic [11:0] pal_color, // palette entry for 8bpp pixel mode
  input wire logic [1:0] depth, // colour depth
  input wire logic pixel_mode, // per-pixel alpha requested
  input wire logic [7:0] alpha_reg, // whole-picture alpha in 32nds
  output logic [23:0] blend_pix // packed blended pixel
);
  import bteb_pkg::*;

  logic [5:0] weight;
  logic [23:0] s0_rgb;
  logic [23:0] s1_rgb;
  logic [23:0] mix_rgb;

  // ----------------------------------------------------------------------
  // weight and source one colour
  // ----------------------------------------------------------------------
  always_comb begin
    s0_rgb = bteb_unpack(src0_pix, depth);
    if (!pixel_mode || depth[1]) begin
      // picture mode, also the fallback at 24bpp
      weight = (alpha_reg > {2'h0, BTEB_W_FULL}) ? BTEB_W_FULL : alpha_reg[5:0];
      s1_rgb = bteb_unpack(src1_pix, depth);
    end else if (depth == BTEB_DEPTH_16) begin
      weight = (src1_pix[15:12] == BTEB_A4_FULL) ? BTEB_W_FULL : {1'b0, src1_pix[15:12], 1'b0};
      s1_rgb = bteb_unpack444(src1_pix[11:0]);
    end else begin
      unique case (src1_pix[7:6])
        2'h0: weight = 6'h00;
        2'h1: weight = BTEB_W2_ONE;
        2'h2: weight = BTEB_W2_TWO;
        2'h3: weight = BTEB_W_FULL;
      endcase
      s1_rgb = bteb_unpack444(pal_color);
    end
  end

  // ----------------------------------------------------------------------
  // per-channel mix, fraction dropped
  // ----------------------------------------------------------------------
  for (genvar ch = 0; ch < 3; ch++) begin : g_chan
    logic [13:0] mix;
    assign mix = 14'(s0_rgb[ch*8 +: 8]) * 14'(weight)
               + 14'(s1_rgb[ch*8 +: 8]) * 14'(BTEB_W_FULL - weight);
    assign mix_rgb[ch*8 +: 8] = mix[BTEB_W_SHIFT +: 8];
  end

  assign blend_pix = bteb_pack(mix_rgb, depth);

endmodule // bteb_blend

//--- rtl/bteb_engine.sv
// bteb_engine: colour expansion, opacity blend and solid fill engine with register port
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps

module bteb_engine (
  input wire logic sys_clk, // system clock
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // register write data
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  input wire logic host_valid, // host source word present
  input wire logic [15:0] host_data, // host source word
  output logic host_ready, // host word taken when valid
  input wire logic src0_valid, // memory source zero word present
  input wire logic [23:0] src0_data, // memory source zero word
  output logic src0_ready, // memory source zero taken
  input wire logic src1_valid, // memory source one pixel present
  input wire logic [23:0] src1_data, // memory source one pixel
  output logic src1_ready, // memory source one taken
  input wire logic dst_ready, // destination accepts beat
  output bteb_pkg::bteb_pix_t dst_pix, // destination pixel beat
  output logic busy // engine active
);
  import bteb_pkg::*;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [7:0] cfg_q;
  logic [7:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  logic [11:0] width_q;
  logic [11:0] height_q;
  logic [5:0] pal_idx_q;
  logic [7:0] pal_lo_q;
  logic [7:0] alpha_q;
  logic [23:0] fg_q;
  logic [23:0] bg_q;
  logic [11:0] pal_mem [64];
  bteb_state_t state_q;
  logic [11:0] x_q;
  logic [11:0] y_q;
  logic [3:0] bit_q;
  logic s0_have_q;
  logic [23:0] s0_q;
  logic s1_have_q;
  logic [23:0] s1_q;
  logic host_ready_q;
  logic src0_ready_q;
  logic src1_ready_q;
  bteb_pix_t dst_q;
  logic busy_q;
  logic [7:0] reg_rdata_q;
  logic [7:0] rd_mux;
  logic [3:0] op;
  logic [1:0] depth;
  logic [3:0] start_bit;
  logic is_fill;
  logic is_blend;
  logic is_expand;
  logic chroma;
  logic from_host;
  logic [3:0] word_msb;
  logic running;
  logic start_go;
  logic s0_take;
  logic s1_take;
  logic [23:0] s0_in;
  logic slot_free;
  logic can_step;
  logic last_x;
  logic last_y;
  logic word_done;
  logic finish;
  logic [23:0] fg_pix;
  logic [23:0] bg_pix;
  logic [23:0] exp_pix;
  logic exp_write;
  logic [23:0] blend_pix;
  logic [23:0] step_color;
  logic step_write;

  // ----------------------------------------------------------------------
  // operation decode
  // ----------------------------------------------------------------------
  assign op = ctrl1_q[3:0];
  assign start_bit = ctrl1_q[BTEB_STARTBIT_MSB:BTEB_STARTBIT_LSB];
  assign depth = ctrl2_q[BTEB_DEPTH_MSB:BTEB_DEPTH_LSB];
  assign is_fill = (op == BTEB_OP_FILL);
  assign is_blend = (op == BTEB_OP_MEM_BLEND) || (op == BTEB_OP_HOST_BLEND);
  assign is_expand = (op == BTEB_OP_HOST_EXP) || (op == BTEB_OP_HOST_EXP_CK)
                  || (op == BTEB_OP_MEM_EXP) || (op == BTEB_OP_MEM_EXP_CK);
  assign chroma = (op == BTEB_OP_HOST_EXP_CK) || (op == BTEB_OP_MEM_EXP_CK);
  assign from_host = (op == BTEB_OP_HOST_EXP) || (op == BTEB_OP_HOST_EXP_CK)
                  || (op == BTEB_OP_HOST_BLEND);

  // word width: host port width for host data, colour depth for memory data
  always_comb begin
    if (from_host) begin
      word_msb = cfg_q[BTEB_CFG_HOST16_BIT] ? BTEB_MSB_16 : BTEB_MSB_8;
    end else begin
      word_msb = (depth == BTEB_DEPTH_8) ? BTEB_MSB_8 : BTEB_MSB_16;
    end
  end

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  assign running = (state_q == BTEB_RUN);
  assign start_go = reg_wr && (reg_addr == BTEB_CFG_OFS) && reg_wdata[BTEB_CFG_START_BIT]
                 && !running && !dst_q.valid;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= BTEB_REG_RST;
      ctrl1_q <= BTEB_REG_RST;
      ctrl2_q <= BTEB_REG_RST;
      width_q <= BTEB_DIM_RST;
      height_q <= BTEB_DIM_RST;
      pal_idx_q <= 6'h00;
      pal_lo_q <= BTEB_REG_RST;
      alpha_q <= BTEB_REG_RST;
      fg_q <= 24'h000000;
      bg_q <= 24'h000000;
    end else if (reg_wr) begin
      unique case (reg_addr)
        BTEB_CFG_OFS: cfg_q <= {3'h0, 1'b0, 2'h0, reg_wdata[1:0]};
        BTEB_CTRL1_OFS: ctrl1_q <= reg_wdata;
        BTEB_CTRL2_OFS: ctrl2_q <= reg_wdata;
        BTEB_WIDTH_LO_OFS: width_q[7:0] <= reg_wdata;
        BTEB_WIDTH_HI_OFS: width_q[11:8] <= reg_wdata[3:0];
        BTEB_HEIGHT_LO_OFS: height_q[7:0] <= reg_wdata;
        BTEB_HEIGHT_HI_OFS: height_q[11:8] <= reg_wdata[3:0];
        BTEB_PAL_IDX_OFS: pal_idx_q <= reg_wdata[5:0];
        BTEB_PAL_LO_OFS: pal_lo_q <= reg_wdata;
        BTEB_ALPHA_OFS: alpha_q <= reg_wdata;
        BTEB_FG_R_OFS: fg_q[23:16] <= reg_wdata;
        BTEB_FG_G_OFS: fg_q[15:8] <= reg_wdata;
        BTEB_FG_B_OFS: fg_q[7:0] <= reg_wdata;
        BTEB_BG_R_OFS: bg_q[23:16] <= reg_wdata;
        BTEB_BG_G_OFS: bg_q[15:8] <= reg_wdata;
        BTEB_BG_B_OFS: bg_q[7:0] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // palette ram, entry written on the high-nibble write
  always_ff @(posedge sys_clk) begin
    if (reg_wr && (reg_addr == BTEB_PAL_HI_OFS)) begin
      pal_mem[pal_idx_q] <= {reg_wdata[3:0], pal_lo_q};
    end
  end

  // ----------------------------------------------------------------------
  // register reads, data valid only in the cycle after the strobe
  // ----------------------------------------------------------------------
  always_comb begin
    unique case (reg_addr)
      BTEB_STATUS_OFS: rd_mux = {4'h0, busy_q, 3'h0};
      BTEB_CFG_OFS: rd_mux = cfg_q;
      BTEB_CTRL1_OFS: rd_mux = ctrl1_q;
      BTEB_CTRL2_OFS: rd_mux = ctrl2_q;
      BTEB_WIDTH_LO_OFS: rd_mux = width_q[7:0];
      BTEB_WIDTH_HI_OFS: rd_mux = {4'h0, width_q[11:8]};
      BTEB_HEIGHT_LO_OFS: rd_mux = height_q[7:0];
      BTEB_HEIGHT_HI_OFS: rd_mux = {4'h0, height_q[11:8]};
      BTEB_PAL_IDX_OFS: rd_mux = {2'h0, pal_idx_q};
      BTEB_PAL_LO_OFS: rd_mux = pal_lo_q;
      BTEB_ALPHA_OFS: rd_mux = alpha_q;
      BTEB_FG_R_OFS: rd_mux = fg_q[23:16];
      BTEB_FG_G_OFS: rd_mux = fg_q[15:8];
      BTEB_FG_B_OFS: rd_mux = fg_q[7:0];
      BTEB_BG_R_OFS: rd_mux = bg_q[23:16];
      BTEB_BG_G_OFS: rd_mux = bg_q[15:8];
      BTEB_BG_B_OFS: rd_mux = bg_q[7:0];
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_q <= 8'h00;
    end else begin
      reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // source handshakes and step condition
  // ----------------------------------------------------------------------
  assign s0_take = from_host ? (host_valid && host_ready_q) : (src0_valid && src0_ready_q);
  assign s1_take = src1_valid && src1_ready_q;
  assign s0_in = from_host ? {8'h00, host_data} : src0_data;
  assign slot_free = !dst_q.valid || dst_ready;
  assign can_step = running && slot_free && (is_fill || s0_have_q) && (!is_blend || s1_have_q);
  assign last_x = (x_q == 12'(width_q - 12'h001));
  assign last_y = (y_q == 12'(height_q - 12'h001));
  assign word_done = is_expand ? ((bit_q == 4'h0) || last_x) : 1'b1;
  assign finish = can_step && last_x && last_y;

  // held source zero word
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s0_have_q <= 1'b0;
      s0_q <= 24'h000000;
    end else if (start_go) begin
      s0_have_q <= 1'b0;
    end else if (s0_take) begin
      s0_have_q <= 1'b1;
      s0_q <= s0_in;
    end else if (can_step && word_done && !is_fill) begin
      s0_have_q <= 1'b0;
    end
  end

  // held source one pixel
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_have_q <= 1'b0;
      s1_q <= 24'h000000;
    end else if (start_go) begin
      s1_have_q <= 1'b0;
    end else if (s1_take) begin
      s1_have_q <= 1'b1;
      s1_q <= src1_data;
    end else if (can_step && is_blend) begin
      s1_have_q <= 1'b0;
    end
  end

  // ready flags, raised while a word is wanted and none is held
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_ready_q <= 1'b0;
      src0_ready_q <= 1'b0;
      src1_ready_q <= 1'b0;
    end else begin
      host_ready_q <= running && from_host && !is_fill && !s0_have_q && !s0_take;
      src0_ready_q <= running && !from_host && !is_fill && !s0_have_q && !s0_take;
      src1_ready_q <= running && is_blend && !s1_have_q && !s1_take;
    end
  end

  // ----------------------------------------------------------------------
  // window walk: column, row and bit position
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= BTEB_IDLE;
      x_q <= BTEB_DIM_RST;
      y_q <= BTEB_DIM_RST;
      bit_q <= 4'h0;
    end else if (start_go) begin
      state_q <= BTEB_RUN;
      x_q <= BTEB_DIM_RST;
      y_q <= BTEB_DIM_RST;
      bit_q <= start_bit;
    end else if (can_step) begin
      if (finish) begin
        state_q <= BTEB_IDLE;
      end
      if (last_x) begin
        // rest of the word is dropped, next row opens a fresh word
        x_q <= BTEB_DIM_RST;
        y_q <= 12'(y_q + 12'h001);
        bit_q <= start_bit;
      end else begin
        x_q <= 12'(x_q + 12'h001);
        bit_q <= (bit_q == 4'h0) ? word_msb : 4'(bit_q - 4'h1);
      end
    end
  end

  // ----------------------------------------------------------------------
  // pixel generators
  // ----------------------------------------------------------------------
  assign fg_pix = bteb_pack(fg_q, depth);
  assign bg_pix = bteb_pack(bg_q, depth);

  bteb_expand u_expand (
    .src_word(s0_q[15:0]),
    .bit_idx(bit_q),
    .fg_pix(fg_pix),
    .bg_pix(bg_pix),
    .chroma(chroma),
    .exp_pix(exp_pix),
    .exp_write(exp_write)
  );

  bteb_blend u_blend (
    .src0_pix(s0_q),
    .src1_pix(s1_q),
    .pal_color(pal_mem[s1_q[5:0]]),
    .depth(depth),
    .pixel_mode(cfg_q[BTEB_CFG_PIXMODE_BIT]),
    .alpha_reg(alpha_q),
    .blend_pix(blend_pix)
  );

  // choose the beat for the current operation
  always_comb begin
    if (is_fill) begin
      step_color = fg_pix;
      step_write = 1'b1;
    end else if (is_blend) begin
      step_color = blend_pix;
      step_write = 1'b1;
    end else begin
      step_color = exp_pix;
      step_write = exp_write;
    end
  end

  // ----------------------------------------------------------------------
  // destination beat register and busy flag
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dst_q <= '0;
    end else if (can_step) begin
      dst_q.valid <= 1'b1;
      dst_q.write <= step_write;
      dst_q.color <= step_color;
    end else if (dst_ready) begin
      dst_q.valid <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= start_go || (running && !finish) || can_step
             || (dst_q.valid && !dst_ready);
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign host_ready = host_ready_q;
  assign src0_ready = src0_ready_q;
  assign src1_ready = src1_ready_q;
  assign dst_pix = dst_q;
  assign busy = busy_q;

endmodule // bteb_engine

//--- rtl/bteb_expand.sv
// bteb_expand: one monochrome bit to a foreground or background pixel
`timescale 1ns/1ps
module bteb_expand (
  input wire logic [15:0] src_word, // source word under expansion
  input wire logic [3:0] bit_idx, // bit of the word for this pixel
  input wire logic [23:0] fg_pix, // packed foreground colour
  input wire logic [23:0] bg_pix, // packed background colour
  input wire logic chroma, // zero bits leave destination alone
  output logic [23:0] exp_pix, // expanded colour
  output logic exp_write // pixel must be written
);
  import bteb_pkg::*;

  logic mono_bit;

  // ----------------------------------------------------------------------
  // bit select and colour choice
  // ----------------------------------------------------------------------
  assign mono_bit = src_word[bit_idx];
  assign exp_pix = mono_bit ? fg_pix : bg_pix;
  assign exp_write = mono_bit | ~chroma;

endmodule // bteb_expand

//--- rtl/bteb_pkg.sv
// bteb_pkg: register map, field layout, encodings and colour helpers for the blend/fill engine
package bteb_pkg;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] BTEB_STATUS_OFS = 8'h00;
  localparam logic [7:0] BTEB_CFG_OFS = 8'h90;
  localparam logic [7:0] BTEB_CTRL1_OFS = 8'h91;
  localparam logic [7:0] BTEB_CTRL2_OFS = 8'h92;
  localparam logic [7:0] BTEB_WIDTH_LO_OFS = 8'h98;
  localparam logic [7:0] BTEB_WIDTH_HI_OFS = 8'h99;
  localparam logic [7:0] BTEB_HEIGHT_LO_OFS = 8'h9A;
  localparam logic [7:0] BTEB_HEIGHT_HI_OFS = 8'h9B;
  localparam logic [7:0] BTEB_PAL_IDX_OFS = 8'hA0;
  localparam logic [7:0] BTEB_PAL_LO_OFS = 8'hA1;
  localparam logic [7:0] BTEB_PAL_HI_OFS = 8'hA2;
  localparam logic [7:0] BTEB_ALPHA_OFS = 8'hB5;
  localparam logic [7:0] BTEB_FG_R_OFS = 8'hD2;
  localparam logic [7:0] BTEB_FG_G_OFS = 8'hD3;
  localparam logic [7:0] BTEB_FG_B_OFS = 8'hD4;
  localparam logic [7:0] BTEB_BG_R_OFS = 8'hD5;
  localparam logic [7:0] BTEB_BG_G_OFS = 8'hD6;
  localparam logic [7:0] BTEB_BG_B_OFS = 8'hD7;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int BTEB_CFG_HOST16_BIT = 0;
  localparam int BTEB_CFG_PIXMODE_BIT = 1;
  localparam int BTEB_CFG_START_BIT = 4;
  localparam int BTEB_STATUS_BUSY_BIT = 3;
  localparam int BTEB_STARTBIT_MSB = 7;
  localparam int BTEB_STARTBIT_LSB = 4;
  localparam int BTEB_DEPTH_MSB = 6;
  localparam int BTEB_DEPTH_LSB = 5;
  localparam logic [7:0] BTEB_REG_RST = 8'h00;
  localparam logic [11:0] BTEB_DIM_RST = 12'h000;

  // ----------------------------------------------------------------------
  // operation codes (low nibble of control 1) and colour depths
  // ----------------------------------------------------------------------
  localparam logic [3:0] BTEB_OP_HOST_EXP = 4'h0;
  localparam logic [3:0] BTEB_OP_HOST_EXP_CK = 4'h1;
  localparam logic [3:0] BTEB_OP_MEM_EXP = 4'h2;
  localparam logic [3:0] BTEB_OP_MEM_EXP_CK = 4'h3;
  localparam logic [3:0] BTEB_OP_MEM_BLEND = 4'h4;
  localparam logic [3:0] BTEB_OP_HOST_BLEND = 4'h5;
  localparam logic [3:0] BTEB_OP_FILL = 4'h6;
  localparam logic [1:0] BTEB_DEPTH_8 = 2'h0;
  localparam logic [1:0] BTEB_DEPTH_16 = 2'h1;
  localparam logic [3:0] BTEB_MSB_8 = 4'h7;
  localparam logic [3:0] BTEB_MSB_16 = 4'hF;

  // ----------------------------------------------------------------------
  // blend weights in 32nds
  // ----------------------------------------------------------------------
  localparam logic [5:0] BTEB_W_FULL = 6'h20;
  localparam logic [5:0] BTEB_W2_ONE = 6'h0A;
  localparam logic [5:0] BTEB_W2_TWO = 6'h15;
  localparam logic [3:0] BTEB_A4_FULL = 4'hF;
  localparam int BTEB_W_SHIFT = 5;

  // one destination pixel beat: advance always, write only when set
  typedef struct packed {
    logic valid;
    logic write;
    logic [23:0] color;
  } bteb_pix_t;

  typedef enum logic {BTEB_IDLE, BTEB_RUN} bteb_state_t;

  // 8-bit r,g,b (msb aligned) to pixel of the given depth
  function automatic logic [23:0] bteb_pack(input logic [23:0] rgb, input logic [1:0] depth);
    if (depth == BTEB_DEPTH_8) return {16'h0000, rgb[23:21], rgb[15:13], rgb[7:6]};
    else if (depth == BTEB_DEPTH_16) return {8'h00, rgb[23:19], rgb[15:10], rgb[7:3]};
    else return rgb;
  endfunction

  // pixel of the given depth to msb aligned 8-bit r,g,b
  function automatic logic [23:0] bteb_unpack(input logic [23:0] p, input logic [1:0] depth);
    if (depth == BTEB_DEPTH_8) return {p[7:5], 5'h00, p[4:2], 5'h00, p[1:0], 6'h00};
    else if (depth == BTEB_DEPTH_16) return {p[15:11], 3'h0, p[10:5], 2'h0, p[4:0], 3'h0};
    else return p;
  endfunction

  // 4:4:4 colour to msb aligned 8-bit r,g,b
  function automatic logic [23:0] bteb_unpack444(input logic [11:0] c);
    return {c[11:8], 4'h0, c[7:4], 4'h0, c[3:0], 4'h0};
  endfunction

endpackage

//--- verification/bteb_engine_monitor.sv
// bteb_engine_monitor: port assertions for the blend/fill engine
`timescale 1ns/1ps
module bteb_engine_monitor (
  input wire logic sys_clk, // clock
  input wire logic arst_n, // reset, active low
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic host_valid, // host word present
  input wire logic [15:0] host_data, // host word
  input wire logic host_ready, // host word taken
  input wire logic src0_valid, // source zero present
  input wire logic [23:0] src0_data, // source zero word
  input wire logic src0_ready, // source zero taken
  input wire logic src1_valid, // source one present
  input wire logic [23:0] src1_data, // source one pixel
  input wire logic src1_ready, // source one taken
  input wire logic dst_ready, // destination accepts
  input wire bteb_pkg::bteb_pix_t dst_pix, // destination beat
  input wire logic busy // engine active
);
  import bteb_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // handshake steps
  sequence s_host_take; host_valid && host_ready; endsequence
  sequence s_src0_take; src0_valid && src0_ready; endsequence
  sequence s_src1_take; src1_valid && src1_ready; endsequence
  sequence s_beat_wait; dst_pix.valid && !dst_ready; endsequence
  a_rd_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  a_status_form: assert property ($past(reg_rd) && $past(reg_addr) == BTEB_STATUS_OFS
    |-> reg_rdata[7:4] == 4'h0 && reg_rdata[2:0] == 3'h0) else $error("status spare bits set");
  a_beat_hold: assert property (s_beat_wait |=> $stable(dst_pix))
    else $error("beat changed while stalled");
  a_host_drop: assert property (s_host_take |=> !host_ready)
    else $error("host ready held after take");
  a_src0_drop: assert property (s_src0_take |=> !src0_ready)
    else $error("source zero ready held after take");
  a_src1_drop: assert property (s_src1_take |=> !src1_ready)
    else $error("source one ready held after take");
  a_idle_ready: assert property (!busy |-> !(host_ready || src0_ready || src1_ready))
    else $error("ready while idle");
  a_beat_busy: assert property (dst_pix.valid |-> busy)
    else $error("beat while idle");
endmodule // bteb_engine_monitor

bind bteb_engine bteb_engine_monitor u_mon (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .host_valid, .host_data, .host_ready, .src0_valid, .src0_data,
  .src0_ready, .src1_valid, .src1_data, .src1_ready, .dst_ready, .dst_pix, .busy);

//--- verification/bteb_engine_tb.sv
// bteb_engine_tb: register-driven expansion, blend and fill scenarios
`timescale 1ns/1ps
module bteb_engine_tb;
  import bteb_pkg::*;
  logic sys_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rewind = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
  logic host_valid, host_ready, src0_valid, src0_ready, src1_valid, src1_ready, dst_ready, busy;
  logic [15:0] host_data;
  logic [23:0] src0_data, src1_data, s1w = 24'h000000;
  logic [3:0][23:0] s0w = {24'h0000DF, 24'h0000EC, 24'h0000DF, 24'h0000EC};
  logic [9:0] pat = 10'h2CD;
  logic [7:0] c;
  bteb_pix_t dst_pix;
  logic [25:0] beats[$];
  int miscompares = 0, total_checks = 0;
  always #50 sys_clk = ~sys_clk;
  bteb_engine DUT (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .host_valid, .host_data, .host_ready, .src0_valid, .src0_data, .src0_ready, .src1_valid,
    .src1_data, .src1_ready, .dst_ready, .dst_pix, .busy);
  bteb_mem_model PEER (.sys_clk, .arst_n, .rewind, .s0w, .s1w, .host_ready, .src0_ready,
    .src1_ready, .host_valid, .host_data, .src0_valid, .src0_data, .src1_valid, .src1_data,
    .dst_ready);
  // collect accepted beats
  always @(posedge sys_clk) if (dst_pix.valid && dst_ready) beats.push_back(dst_pix);
  task automatic check(input logic [25:0] seen, input logic [25:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // write strobe stays up for back-to-back writes; the next read lowers it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
    @(posedge sys_clk);
  endtask
  // start one operation, wait for idle, check beat count
  task automatic run(input logic [3:0] op, input logic [7:0] cfg, input int n);
    int k;
    beats.delete();
    rewind <= 1'b1;
    wr(BTEB_CTRL1_OFS, {4'h5, op});
    rewind <= 1'b0;
    wr(BTEB_CFG_OFS, cfg | 8'h10);
    rd(BTEB_STATUS_OFS, v);
    check(v, 8'h08);
    for (k = 0; k < 3000 && busy !== 1'b0; k++) @(negedge sys_clk);
    @(posedge sys_clk);
    check(26'(beats.size()), 26'(n));
  endtask
  // watchdog
  initial begin
    repeat (30000) @(posedge sys_clk);
    miscompares++;
    summarize();
  end
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    rd(8'h55, v);
    check(v, 8'h00);
    for (int i = 0; i < 6; i++) wr(8'hD2 + 8'(i), (i == 0 || i == 5) ? 8'hFF : 8'h00);
    wr(BTEB_WIDTH_LO_OFS, 8'd10);
    wr(BTEB_HEIGHT_LO_OFS, 8'd2);
    for (int op = 0; op < 4; op++) begin
      run(4'(op), 8'h00, 20);
      for (int i = 0; i < 20; i++) begin
        if (pat[9 - i % 10]) check(beats[i], 26'h30000E0);
        else if (op % 2 == 1) check(beats[i][25:24], 2'b10);
        else check(beats[i], 26'h3000003);
      end
    end
    // 16-bit host words: second word of each row gives its top four bits
    run(BTEB_OP_HOST_EXP, 8'h01, 20);
    for (int i = 0; i < 20; i++) begin
      if (pat[9 - i % 10] && i % 10 < 6) check(beats[i], 26'h30000E0);
      else check(beats[i], 26'h3000003);
    end
    wr(BTEB_WIDTH_LO_OFS, 8'd3);
    run(BTEB_OP_FILL, 8'h00, 6);
    for (int i = 0; i < 6; i++) check(beats[i], 26'h30000E0);
    wr(BTEB_WIDTH_LO_OFS, 8'd1);
    wr(BTEB_HEIGHT_LO_OFS, 8'd1);
    wr(BTEB_ALPHA_OFS, 8'h10);
    s0w[0] = 24'h0000FF;
    run(BTEB_OP_MEM_BLEND, 8'h00, 1);
    check(beats[0], 26'h300006D);
    wr(BTEB_PAL_IDX_OFS, 8'h00);
    wr(BTEB_PAL_LO_OFS, 8'hFF);
    wr(BTEB_PAL_HI_OFS, 8'h0F);
    s0w[0] = 24'h000000;
    for (int n = 0; n < 4; n++) begin
      s1w = {16'h0000, 2'(n), 6'h00};
      run(BTEB_OP_MEM_BLEND, 8'h02, 1);
      c = 8'((240 * (n == 0 ? 32 : n == 1 ? 22 : n == 2 ? 11 : 0)) >> 5);
      check(beats[0], {2'b11, 16'h0000, c[7:5], c[7:5], c[7:6]});
    end
    wr(BTEB_CTRL2_OFS, 8'h20);
    for (int n = 0; n < 16; n++) begin
      s1w = {8'h00, 4'(n), 12'hFFF};
      run(BTEB_OP_HOST_BLEND, 8'h02, 1);
      c = 8'((240 * (n == 15 ? 0 : 32 - 2 * n)) >> 5);
      check(beats[0], {2'b11, 8'h00, c[7:3], c[7:2], c[7:3]});
    end
    summarize();
  end
endmodule // bteb_engine_tb

//--- verification/bteb_mem_model.sv
// bteb_mem_model: host and memory sources plus a stalling destination
`timescale 1ns/1ps
module bteb_mem_model (
  input wire logic sys_clk, // clock
  input wire logic arst_n, // reset, active low
  input wire logic rewind, // restart word list
  input wire logic [3:0][23:0] s0w, // source zero words
  input wire logic [23:0] s1w, // source one pixel
  input wire logic host_ready, // host word taken
  input wire logic src0_ready, // source zero taken
  input wire logic src1_ready, // source one taken
  output logic host_valid, // host word present
  output logic [15:0] host_data, // host word
  output logic src0_valid, // source zero present
  output logic [23:0] src0_data, // source zero word
  output logic src1_valid, // source one present
  output logic [23:0] src1_data // source one pixel
  ,output logic dst_ready // destination accepts
);
  logic [1:0] idx_q;
  logic [1:0] cnt_q;
  // next word only after a take; stall counter runs free
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      idx_q <= 2'h0;
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      if (rewind) idx_q <= 2'h0;
      else if (host_valid && host_ready || src0_valid && src0_ready) idx_q <= idx_q + 2'h1;
    end
  end
  // words held until taken
  assign host_valid = 1'b1;
  assign src0_valid = 1'b1;
  assign src1_valid = 1'b1;
  assign host_data = s0w[idx_q][15:0];
  assign src0_data = s0w[idx_q];
  assign src1_data = s1w;
  assign dst_ready = cnt_q != 2'h3; // stall one cycle in four
endmodule // bteb_mem_model
